// ---- common/acqft_pkg.sv ----
// shared constants for the acquisition fifo and timer port block
package acqft_pkg;
    // byte offsets on the register bus
    localparam logic [5:0] OFF_RESULT = 6'h16; // read: result fifo, write: dma tc clear
    localparam logic [5:0] OFF_TDATA = 6'h18;
    localparam logic [5:0] OFF_TSTAT = 6'h1a;
    localparam logic [5:0] OFF_TCMD = 6'h1c;
    localparam logic [5:0] OFF_CMD1 = 6'h20;
    localparam logic [5:0] OFF_STAT = 6'h24;
    localparam logic [5:0] OFF_IRQST = 6'h28;
    localparam logic [5:0] OFF_IRQMSK = 6'h2c;
    // field positions
    localparam int CMD1_TWOS_N_BIT = 0;
    localparam int CMD1_DROP_BIT = 1;
    localparam int STAT_AVAIL_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int IRQ_TC_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int TSTAT_BYTE_POINTER_STATE_BIT = 0;
    localparam int TSTAT_OUT_LSB = 1;
    localparam int SAMPLE_MSB = 11;
    // reset values
    localparam logic [15:0] CMD1_RESET = 16'h0001;
    localparam logic [1:0] IRQMSK_RESET = 2'h0;
    localparam logic [7:0] TCMD_HIGH = 8'hff;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    // fifo shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // timer register count reachable through the data port
    localparam int TIMER_NREG = 18;
    // bus state machine
    typedef enum logic [2:0]
    {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } acqft_bus_t;
endpackage

// ---- core/acqft_result_fifo.sv ----
// result fifo holding finished conversions
`timescale 1ns/100ps
`default_nettype none
module acqft_result_fifo
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pushValid,
    input wire logic [11:0] pushData,
    input wire logic dropOnFull,
    input wire logic popReq,
    output logic [11:0] headData,
    output logic notEmpty,
    output logic overflowPulse
);
    logic [11:0] mem [acqft_pkg::FIFO_DEPTH];
    logic [acqft_pkg::FIFO_AW-1:0] wrPtr_r;
    logic [acqft_pkg::FIFO_AW-1:0] rdPtr_r;
    logic [acqft_pkg::FIFO_AW:0] count_r;
    logic isFull;
    logic doPop;
    logic doPush;
    logic doOverwrite;

    // on full either drop the new sample or overwrite the oldest one
    assign isFull = (count_r == 5'(acqft_pkg::FIFO_DEPTH));
    assign doPop = popReq && (count_r != '0); // R05
    assign doOverwrite = pushValid && isFull && !dropOnFull && !doPop; // R18
    assign doPush = pushValid && (!isFull || doPop || doOverwrite); // R02
    assign notEmpty = (count_r != '0); // R03
    assign headData = mem[rdPtr_r];
    assign overflowPulse = pushValid && isFull && !doPop;

    // storage, no reset needed for data words
    always_ff @(posedge clk_sys)
    begin
        if (doPush)
        begin
            mem[wrPtr_r] <= pushData; // R02
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doPop || doOverwrite)
            begin
                rdPtr_r <= rdPtr_r + 1'b1; // R01
            end
            if (doPush && !doPop && !doOverwrite)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (doPop && !doPush)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    a_pop_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (doPop && !pushValid) |=> (count_r == $past(count_r) - 1'b1)) // R01
        else $error("pop did not free an entry");
    a_empty_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!notEmpty && popReq && !pushValid) |=> !notEmpty) // R05
        else $error("empty read changed the fifo");
    a_push_grow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (pushValid && !isFull && !popReq) |=> (count_r == $past(count_r) + 1'b1)) // R02
        else $error("conversion not stored");
endmodule // acqft_result_fifo
`default_nettype wire

// ---- core/acqft_timer_if.sv ----
// bridge to the external counter/timer chip
`timescale 1ns/100ps
`default_nettype none
module acqft_timer_if
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic dataWr,
    input wire logic dataRd,
    input wire logic cmdWr,
    input wire logic [15:0] wrData,
    input wire logic [15:0] tmrRdData,
    input wire logic [5:1] tmrOutPin,
    input wire logic tmrBytePtr,
    output logic tmrDataWr_r,
    output logic tmrDataRd_r,
    output logic tmrCmdWr_r,
    output logic [15:0] tmrWrData_r,
    output logic [15:0] statusWord
);
    logic [5:0] pinMeta_r;
    logic [5:0] pinSync_r;

    // strobes forwarded as one-cycle pulses to the chip, write data held until the next data or command write
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tmrDataWr_r <= 1'b0;
            tmrDataRd_r <= 1'b0;
            tmrCmdWr_r <= 1'b0;
            tmrWrData_r <= 16'h0000;
        end
        else
        begin
            tmrDataWr_r <= dataWr; // R12
            tmrDataRd_r <= dataRd; // R11
            tmrCmdWr_r <= cmdWr; // R19
            if (dataWr || cmdWr)
            begin
                tmrWrData_r <= wrData; // R13
            end
        end
    end

    // counter outputs are asynchronous pins, two flops before use
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pinMeta_r <= 6'h00;
            pinSync_r <= 6'h00;
        end
        else
        begin
            pinMeta_r <= {tmrOutPin, tmrBytePtr};
            pinSync_r <= pinMeta_r;
        end
    end

    assign statusWord = {10'h000, pinSync_r}; // R15 R16
endmodule // acqft_timer_if
`default_nettype wire

// ---- core/acqft_port.sv ----
// acquisition fifo read port, dma tc clear and counter/timer access registers
// Operation
// R01 - fifo port read returns oldest word and removes it
// R02 - every finished conversion is pushed into the fifo; with the drop bit set, one arriving at a full fifo is lost
// R03 - available flag high while fifo holds at least one result
// R04 - software checks available flag before reading fifo port
// R05 - reading empty fifo returns junk and leaves fifo unchanged
// R06 - format chosen by twos complement select bit in command one
// R07 - straight binary: 12 bits low, top four bits zero
// R08 - twos complement: inverted bit 11 copied to bits 15..11
// R09 - dma terminal count pulse raises request held until cleared
// R10 - any write at 0x16 clears tc request; read gives fifo
// R11 - command write selects timer register, data port reaches it
// R12 - data port writes load, reads return selected timer register
// R13 - timer exposes eighteen 16-bit internal registers
// R14 - software sets command bits 15..8 high, low byte is command
// R15 - status port bits 5..1 give counter output levels
// R16 - status port bit 0 gives byte pointer state
// R17 - software uses timer only in sixteen-bit bus mode
// R18 - fifo depth parameter, overflow policy configurable
// R19 - timer modelled outside, this block only decodes and forwards
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module acqft_port
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic convDone,
    input wire logic [11:0] convData,
    input wire logic dmaTcPulse,
    input wire logic [15:0] tmrRdData,
    input wire logic [5:1] tmrOutPin,
    input wire logic tmrBytePtr,
    output logic tmrDataWr,
    output logic tmrDataRd,
    output logic tmrCmdWr,
    output logic [15:0] tmrWrData,
    output logic irq
);
    acqft_pkg::acqft_bus_t busState_r;
    logic [31:0] readData_r;
    logic [15:0] cmd1_r;
    logic [1:0] irqStatus_r;
    logic [1:0] irqMask_r;
    logic irq_r;
    logic ovfSticky_r;
    logic [11:0] headData;
    logic notEmpty;
    logic overflowPulse;
    logic [15:0] tmrStatus;
    logic isAccess;
    logic wrStrobe;
    logic rdStrobe;
    logic fifoPop;
    logic tcClear;
    logic [15:0] fmtWord;
    logic tmrDataWrQ;
    logic tmrDataRdQ;
    logic tmrCmdWrQ;
    logic [15:0] tmrWrDataQ;
    logic [1:0] dmaSync_r;
    logic dmaPrev_r;
    logic dmaRise;

    // convert a 12-bit sample to the selected output format
    function automatic logic [15:0] fmt_sample(input logic [11:0] s, input logic twosN);
        logic msbInv;
        msbInv = ~s[acqft_pkg::SAMPLE_MSB];
        if (twosN)
        begin
            fmt_sample = {4'h0, s}; // R07
        end
        else
        begin
            fmt_sample = {{5{msbInv}}, s[10:0]}; // R08
        end
    endfunction

    // the access is taken once, in the cycle the fsm leaves idle
    assign isAccess = (busState_r == acqft_pkg::BUS_IDLE) && (avs_read || avs_write);
    assign wrStrobe = isAccess && avs_write;
    assign rdStrobe = isAccess && avs_read;
    assign fifoPop = rdStrobe && (avs_address == acqft_pkg::OFF_RESULT); // R01
    assign tcClear = wrStrobe && (avs_address == acqft_pkg::OFF_RESULT); // R10
    assign fmtWord = fmt_sample(headData, cmd1_r[acqft_pkg::CMD1_TWOS_N_BIT]); // R06

    acqft_result_fifo u_fifo
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pushValid(convDone),
        .pushData(convData),
        .dropOnFull(cmd1_r[acqft_pkg::CMD1_DROP_BIT]),
        .popReq(fifoPop),
        .headData(headData),
        .notEmpty(notEmpty),
        .overflowPulse(overflowPulse)
    );

    acqft_timer_if u_timer
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .dataWr(wrStrobe && (avs_address == acqft_pkg::OFF_TDATA)),
        .dataRd(rdStrobe && (avs_address == acqft_pkg::OFF_TDATA)),
        .cmdWr(wrStrobe && (avs_address == acqft_pkg::OFF_TCMD)),
        .wrData(avs_writedata[15:0]),
        .tmrRdData(tmrRdData),
        .tmrOutPin(tmrOutPin),
        .tmrBytePtr(tmrBytePtr),
        .tmrDataWr_r(tmrDataWrQ),
        .tmrDataRd_r(tmrDataRdQ),
        .tmrCmdWr_r(tmrCmdWrQ),
        .tmrWrData_r(tmrWrDataQ),
        .statusWord(tmrStatus)
    );

    // timer strobes already come from flops in the bridge
    assign tmrDataWr = tmrDataWrQ; // R19
    assign tmrDataRd = tmrDataRdQ;
    assign tmrCmdWr = tmrCmdWrQ;
    assign tmrWrData = tmrWrDataQ;

    // bus fsm: idle takes, wait lets the timer answer, done releases
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busState_r <= acqft_pkg::BUS_IDLE;
        end
        else
        begin
            case (busState_r)
                acqft_pkg::BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        busState_r <= acqft_pkg::BUS_WAIT;
                    end
                end
                acqft_pkg::BUS_WAIT:
                begin
                    busState_r <= acqft_pkg::BUS_DONE;
                end
                acqft_pkg::BUS_DONE:
                begin
                    busState_r <= acqft_pkg::BUS_IDLE;
                end
                default:
                begin
                    busState_r <= acqft_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // waitrequest low only in done; high while idle so nothing slips past
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= (busState_r != acqft_pkg::BUS_WAIT);
        end
    end

    // read data mux; fifo word captured at the take, timer word one cycle later
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            readData_r <= acqft_pkg::UNMAPPED_READ;
        end
        else if (rdStrobe)
        begin
            case (avs_address)
                acqft_pkg::OFF_RESULT: readData_r <= {16'h0000, fmtWord}; // R05
                acqft_pkg::OFF_TSTAT: readData_r <= {16'h0000, tmrStatus}; // R15
                acqft_pkg::OFF_CMD1: readData_r <= {16'h0000, cmd1_r};
                acqft_pkg::OFF_STAT: readData_r <= {30'h0, ovfSticky_r, notEmpty}; // R03
                acqft_pkg::OFF_IRQST: readData_r <= {30'h0, irqStatus_r};
                acqft_pkg::OFF_IRQMSK: readData_r <= {30'h0, irqMask_r};
                default: readData_r <= acqft_pkg::UNMAPPED_READ;
            endcase
        end
        else if (busState_r == acqft_pkg::BUS_WAIT && tmrDataRdQ)
        begin
            readData_r <= {16'h0000, tmrRdData}; // R12
        end
    end

    assign avs_readdata = readData_r;

    // command register one low byte and mask, written only when byte lane 0 is enabled
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd1_r <= acqft_pkg::CMD1_RESET;
            irqMask_r <= acqft_pkg::IRQMSK_RESET;
        end
        else if (wrStrobe && avs_byteenable[0])
        begin
            if (avs_address == acqft_pkg::OFF_CMD1)
            begin
                cmd1_r[7:0] <= avs_writedata[7:0]; // R06
            end
            if (avs_address == acqft_pkg::OFF_IRQMSK)
            begin
                irqMask_r <= avs_writedata[1:0];
            end
        end
    end

    // tc pulse from outside the domain, synchronised then edge detected
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dmaSync_r <= 2'h0;
            dmaPrev_r <= 1'b0;
        end
        else
        begin
            dmaSync_r <= {dmaSync_r[0], dmaTcPulse};
            dmaPrev_r <= dmaSync_r[1];
        end
    end

    assign dmaRise = dmaSync_r[1] && !dmaPrev_r;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqStatus_r <= 2'h0;
            ovfSticky_r <= 1'b0;
        end
        else
        begin
            if (dmaRise)
            begin
                irqStatus_r[acqft_pkg::IRQ_TC_BIT] <= 1'b1; // R09
            end
            else if (tcClear || (wrStrobe && avs_address == acqft_pkg::OFF_IRQST
                && avs_writedata[acqft_pkg::IRQ_TC_BIT]))
            begin
                irqStatus_r[acqft_pkg::IRQ_TC_BIT] <= 1'b0; // R10
            end
            if (overflowPulse)
            begin
                irqStatus_r[acqft_pkg::IRQ_OVF_BIT] <= 1'b1; // R18
                ovfSticky_r <= 1'b1;
            end
            else if (wrStrobe && avs_address == acqft_pkg::OFF_IRQST
                && avs_writedata[acqft_pkg::IRQ_OVF_BIT])
            begin
                irqStatus_r[acqft_pkg::IRQ_OVF_BIT] <= 1'b0;
                ovfSticky_r <= 1'b0;
            end
        end
    end

    // level interrupt, registered
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= |(irqStatus_r & irqMask_r);
        end
    end

    assign irq = irq_r;

    sequence s_take;
        (busState_r == acqft_pkg::BUS_IDLE) && (avs_read || avs_write);
    endsequence
    sequence s_answer;
        ##2 !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_take |-> s_answer)
        else $error("bus answer not two cycles after take");
    a_tc_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        dmaRise |=> irqStatus_r[acqft_pkg::IRQ_TC_BIT]) // R09
        else $error("tc request not raised");
    a_tc_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (tcClear && !dmaRise) |=> !irqStatus_r[acqft_pkg::IRQ_TC_BIT]) // R10
        else $error("tc request not cleared");
    a_fmt_binary: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fifoPop && cmd1_r[acqft_pkg::CMD1_TWOS_N_BIT]) |=> (readData_r[15:12] == 4'h0)) // R07
        else $error("straight binary top bits not zero");
    a_fmt_twos: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fifoPop && !cmd1_r[acqft_pkg::CMD1_TWOS_N_BIT])
        |=> (readData_r[15:11] == {5{~$past(headData[11])}})) // R08
        else $error("twos complement extension wrong");
    a_avail_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rdStrobe && avs_address == acqft_pkg::OFF_STAT) |=> (readData_r[0] == $past(notEmpty))) // R03
        else $error("available flag mismatch");
    a_tdata_fwd: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (wrStrobe && avs_address == acqft_pkg::OFF_TDATA)
        |=> tmrDataWr && (tmrWrData == $past(avs_writedata[15:0]))) // R12
        else $error("data port write not forwarded");
    a_tstat_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rdStrobe && avs_address == acqft_pkg::OFF_TSTAT) |=> (readData_r[15:6] == 10'h000)) // R15
        else $error("timer status upper bits set");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (|(irqStatus_r & irqMask_r)) |=> irq)
        else $error("interrupt not raised");
endmodule // acqft_port
`default_nettype wire

// ---- test/acqft_timer_model.sv ----
// behavioural model of the external five-counter timer chip
`timescale 1ns/100ps
`default_nettype none
module acqft_timer_model
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic tmrDataWr,
    input wire logic tmrDataRd,
    input wire logic tmrCmdWr,
    input wire logic [15:0] tmrWrData,
    output logic [15:0] tmrRdData
);
    logic [15:0] regFile_r [0:17]; // mode, load, hold x5, master mode, two compares
    logic [4:0] selIdx_r;
    logic [15:0] lastRd_r;

    // command selects the internal register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            selIdx_r <= 5'h00;
        end
        else if (tmrCmdWr && tmrWrData[15:8] == 8'hff && tmrWrData[7:0] < 8'h12)
        begin
            selIdx_r <= tmrWrData[4:0];
        end
    end

    // data port loads the selected register; last read kept for the idle bus
    always_ff @(posedge clk_sys)
    begin
        if (tmrDataWr)
        begin
            regFile_r[selIdx_r] <= tmrWrData;
        end
        if (tmrDataRd)
        begin
            lastRd_r <= regFile_r[selIdx_r];
        end
    end

    // read data only while selected; released bus shows the inverse, not stale data
    assign tmrRdData = tmrDataRd ? regFile_r[selIdx_r] : ~lastRd_r;
endmodule // acqft_timer_model
`default_nettype wire

// ---- test/acq_fifo_and_timer_port_bench.sv ----
// self-checking bench for the fifo read port, tc clear and timer access block
`timescale 1ns/100ps
`default_nettype none
module acq_fifo_and_timer_port_bench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic convDone = 1'b0;
    logic [11:0] convData = 12'h000;
    logic dmaTcPulse = 1'b0;
    logic [15:0] tmrRdData;
    logic [5:1] tmrOutPin = 5'h00;
    logic tmrBytePtr = 1'b0;
    logic tmrDataWr, tmrDataRd, tmrCmdWr, irq;
    logic [15:0] tmrWrData;
    int failures = 0;
    int comparisons = 0;
    integer seed = 50380;
    logic [31:0] rd;
    logic [11:0] smp;
    logic [11:0] expQ [$];
    logic [15:0] tval [0:17];
    logic twosN;

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    acqft_port i_acqft_port (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .convDone(convDone), .convData(convData), .dmaTcPulse(dmaTcPulse),
        .tmrRdData(tmrRdData), .tmrOutPin(tmrOutPin), .tmrBytePtr(tmrBytePtr),
        .tmrDataWr(tmrDataWr), .tmrDataRd(tmrDataRd), .tmrCmdWr(tmrCmdWr),
        .tmrWrData(tmrWrData), .irq(irq));

    acqft_timer_model i_acqft_timer_model (.clk_sys(clk_sys), .reset_n(reset_n),
        .tmrDataWr(tmrDataWr), .tmrDataRd(tmrDataRd), .tmrCmdWr(tmrCmdWr),
        .tmrWrData(tmrWrData), .tmrRdData(tmrRdData));

    // expected fifo word for either output format
    function automatic logic [31:0] fmt(input logic [11:0] d, input logic tn);
        return tn ? {20'h00000, d} : {16'h0000, {5{~d[11]}}, d[10:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    // one bus transfer, held until waitrequest is sampled low
    // no cycle limit here: only the watchdog ends a hung wait
    task automatic bus_op(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one finished conversion, a single-cycle strobe
    task automatic push(input logic [11:0] d);
        @(posedge clk_sys);
        convDone <= 1'b1;
        convData <= d;
        @(posedge clk_sys);
        convDone <= 1'b0;
        expQ.push_back(d);
    endtask

    // tc pulse held three cycles so the two-flop synchroniser sees it
    task automatic pulse_tc();
        @(posedge clk_sys);
        dmaTcPulse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        dmaTcPulse <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    // drain the expected queue, checking the flag before every read
    task automatic drain(input int cnt);
        repeat (cnt)
        begin
            bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
            check(rd[0], 1'b1);
            bus_op(1'b0, acqft_pkg::OFF_RESULT, 32'h0);
            check(rd, fmt(expQ.pop_front(), twosN));
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog well beyond the roughly one thousand cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        give_verdict();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        check(irq, 1'b0);
        // both formats, corner codes first then random samples
        for (int r = 0; r < 2; r++)
        begin
            twosN = (r == 0);
            bus_op(1'b1, acqft_pkg::OFF_CMD1, {31'h0, twosN});
            for (int i = 0; i < acqft_pkg::FIFO_DEPTH; i++)
            begin
                smp = 12'($random(seed));
                case (i)
                    0: smp = 12'h000;
                    1: smp = 12'h7ff;
                    2: smp = 12'h800;
                    3: smp = 12'hfff;
                    default: ;
                endcase
                push(smp);
            end
            drain(acqft_pkg::FIFO_DEPTH);
            bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
            check(rd[0], 1'b0);
        end
        // empty read must leave the fifo untouched
        bus_op(1'b0, acqft_pkg::OFF_RESULT, 32'h0);
        push(12'h5a5);
        drain(1);
        bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
        check(rd[0], 1'b0);
        // drop-new policy: one push beyond depth is lost and flagged
        twosN = 1'b1;
        bus_op(1'b1, acqft_pkg::OFF_CMD1, 32'h3);
        for (int i = 0; i <= acqft_pkg::FIFO_DEPTH; i++)
            push(12'($random(seed)));
        void'(expQ.pop_back());
        bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
        check(rd[1], 1'b1);
        drain(acqft_pkg::FIFO_DEPTH);
        // write-one clears overflow; overwrite policy then loses the oldest word
        bus_op(1'b1, acqft_pkg::OFF_IRQST, 32'h2);
        bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
        check(rd[1], 1'b0);
        bus_op(1'b1, acqft_pkg::OFF_CMD1, 32'h1);
        for (int i = 0; i <= acqft_pkg::FIFO_DEPTH; i++)
            push(12'($random(seed)));
        void'(expQ.pop_front());
        bus_op(1'b0, acqft_pkg::OFF_STAT, 32'h0);
        check(rd[1], 1'b1);
        drain(acqft_pkg::FIFO_DEPTH);
        // unmasked tc request, cleared by a write at the fifo offset
        bus_op(1'b1, acqft_pkg::OFF_IRQMSK, 32'h1);
        pulse_tc();
        check(irq, 1'b1);
        bus_op(1'b0, acqft_pkg::OFF_IRQST, 32'h0);
        check(rd[0], 1'b1);
        bus_op(1'b1, acqft_pkg::OFF_RESULT, $random(seed));
        repeat (3) @(posedge clk_sys);
        check(irq, 1'b0);
        // masked tc request stays sticky, cleared by write-one
        bus_op(1'b1, acqft_pkg::OFF_IRQMSK, 32'h0);
        pulse_tc();
        check(irq, 1'b0);
        bus_op(1'b0, acqft_pkg::OFF_IRQST, 32'h0);
        check(rd[0], 1'b1);
        bus_op(1'b1, acqft_pkg::OFF_IRQST, 32'h1);
        bus_op(1'b0, acqft_pkg::OFF_IRQST, 32'h0);
        check(rd[0], 1'b0);
        // load every timer register, then read them all back
        for (int i = 0; i < acqft_pkg::TIMER_NREG; i++)
        begin
            tval[i] = 16'($random(seed));
            bus_op(1'b1, acqft_pkg::OFF_TCMD, {24'h0000ff, 3'h0, i[4:0]});
            bus_op(1'b1, acqft_pkg::OFF_TDATA, {16'h0000, tval[i]});
        end
        for (int i = acqft_pkg::TIMER_NREG - 1; i >= 0; i--)
        begin
            bus_op(1'b1, acqft_pkg::OFF_TCMD, {24'h0000ff, 3'h0, i[4:0]});
            bus_op(1'b0, acqft_pkg::OFF_TDATA, 32'h0);
            check(rd, {16'h0000, tval[i]});
        end
        // live counter outputs and byte pointer, after synchroniser delay
        repeat (6)
        begin
            @(posedge clk_sys);
            {tmrOutPin, tmrBytePtr} <= 6'($random(seed));
            repeat (5) @(posedge clk_sys);
            bus_op(1'b0, acqft_pkg::OFF_TSTAT, 32'h0);
            check(rd[5:0], {tmrOutPin, tmrBytePtr});
        end
        bus_op(1'b0, 6'h3c, 32'h0);
        check(rd, acqft_pkg::UNMAPPED_READ);
        give_verdict();
    end
endmodule // acq_fifo_and_timer_port_bench
`default_nettype wire
